/* mbc_pkg.sv */
// Constants and types shared by the modem buffer and mode controller
package mbc_pkg;

  localparam int BUF_AW = 8;
  localparam int RX_FIFO_DEPTH = 32;
  localparam int RX_FIFO_WIDTH = 8;

  // SPI register addresses
  localparam logic [6:0] ADDR_DATA_PORT = 7'h00;
  localparam logic [6:0] ADDR_OPMODE = 7'h01;
  localparam logic [6:0] ADDR_FRF_MSB = 7'h06;
  localparam logic [6:0] ADDR_FRF_MID = 7'h07;
  localparam logic [6:0] ADDR_FRF_LSB = 7'h08;
  localparam logic [6:0] ADDR_PTR = 7'h0d;
  localparam logic [6:0] ADDR_TX_BASE = 7'h0e;
  localparam logic [6:0] ADDR_RX_BASE = 7'h0f;
  localparam logic [6:0] ADDR_LAST_START = 7'h10;
  localparam logic [6:0] ADDR_IRQ_MASK = 7'h11;
  localparam logic [6:0] ADDR_IRQ_FLAGS = 7'h12;
  localparam logic [6:0] ADDR_RX_COUNT = 7'h13;
  localparam logic [6:0] ADDR_TX_LEN = 7'h22;

  // SPI command byte and operating mode register fields
  localparam int SPI_WRITE_BIT = 7;
  localparam int OPM_LR_BIT = 7;
  localparam int OPM_MODE_LSB = 0;

  // Operating modes
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STDBY = 3'h1;
  localparam logic [2:0] MODE_TRANSMIT_SYNTH_MODE = 3'h2;
  localparam logic [2:0] MODE_TX = 3'h3;
  localparam logic [2:0] MODE_RECEIVE_SYNTH_MODE = 3'h4;
  localparam logic [2:0] MODE_RXCONT = 3'h5;
  localparam logic [2:0] MODE_RXONCE = 3'h6;
  localparam logic [2:0] MODE_CAD = 3'h7;

  // Reset values and last buffer address
  localparam logic [7:0] RST_TX_BASE = 8'h80;
  localparam logic [7:0] RST_RX_BASE = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  localparam logic [7:0] RST_TX_LEN = 8'h01;
  localparam logic [23:0] RST_FRF = 24'h000000;
  localparam logic [7:0] BUF_LAST = 8'hff;

  typedef enum logic {PH_ADDR, PH_DATA} mbc_phase_type;

  // Packet events from the modem receive path
  typedef struct packed {
    logic start;
    logic hdr_valid;
    logic [7:0] hdr_len;
    logic done;
  } mbc_rx_evt_type;

endpackage

/* mbc_modem_buffer.sv */
// Modem data buffer, SPI register file and operating mode control
// Summary of operation
// (R1) Config registers read in every mode, kept when long range is off.
// (R2) 256-byte buffer, reachable only while long range mode is on.
// (R3) Buffer readable except in sleep; cleared on each entry to receive.
// (R4) After reset receive base is 0x00, transmit base is 0x80.
// (R5) Both base addresses freely programmable anywhere in the buffer.
// (R6) Entering sleep clears the buffer; no buffer access during sleep.
// (R7) Mode changes other than to sleep or receive keep buffer data; only writes change a byte.
// (R8) Data port access uses the access pointer, then increments it.
// (R9) Host loads the access pointer with a base before each sequence.
// (R10) Transmit length sets bytes sent; header length loads receive count.
// (R11) Start of the latest received packet is recorded for the host.
// (R12) Every received byte is stored, even with a bad payload check.
// (R13) Long receive packets run on into the transmit region.
// (R14) Buffer pointers are eight bits and wrap from top to zero.
// (R15) Mask bit at one disables its interrupt; mask resets to zero.
// (R16) Events set flags; host clears a flag by writing one.
// (R17) Long range bit changes only in sleep; modes need it set.
// (R18) In sleep only SPI and configuration registers are reachable.
// (R19) Standby: oscillator on; synth modes: matching PLL on, RF off.
// (R20) Transmit powers transmit blocks, then returns to standby itself.
// (R21) Single receive returns to standby after a packet; continuous stays.
// (R22) Host may move from any mode to any other mode.
// (R23) Carrier frequency held as a 24-bit word.
`timescale 1ns/100ps

module mbc_stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
    logic ready;
  } mbc_fifo_state_type;

  mbc_fifo_state_type st_reg;
  mbc_fifo_state_type st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  always_comb begin
    st_next = st_reg;
    out_valid_o = (st_reg.wr != st_reg.rd);
    in_ready_o = st_reg.ready;
    out_data_o = mem[st_reg.rd[AW-1:0]];
    push = in_valid_i && st_reg.ready;
    pop = out_valid_o && out_ready_i;
    if (push) begin
      st_next.wr = st_reg.wr + 1'b1;
    end
    if (pop) begin
      st_next.rd = st_reg.rd + 1'b1;
    end
    // Full when pointers differ only in the wrap bit; ready kept as a flop
    st_next.ready = !((st_next.wr[AW-1:0] == st_next.rd[AW-1:0]) &&
                      (st_next.wr[AW] != st_next.rd[AW]));
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[st_reg.wr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '{ready: 1'b1, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

module mbc_modem_buffer
  import mbc_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic SPI_SCK_I,
  input wire logic SPI_CS_N_I,
  input wire logic SPI_MOSI_I,
  output logic SPI_MISO_O,
  output logic SPI_MISO_OE_O,
  input wire logic [7:0] RX_BYTE_I,
  input wire logic RX_VALID_I,
  output logic RX_READY_O,
  input wire mbc_rx_evt_type RX_EVT_I,
  input wire logic IMPLICIT_HDR_I,
  input wire logic TX_BYTE_REQ_I,
  input wire logic TX_DONE_I,
  input wire logic [7:0] IRQ_EVENT_I,
  output logic [7:0] TX_BYTE_O,
  output logic [7:0] TX_LEN_O,
  output logic [2:0] MODE_O,
  output logic LONG_RANGE_O,
  output logic [23:0] FRF_O,
  output logic OSC_ON_O,
  output logic PLL_TX_ON_O,
  output logic PLL_RX_ON_O,
  output logic RF_TX_ON_O,
  output logic RF_RX_ON_O,
  output logic IRQ_O
);

  typedef struct packed {
    logic sck_meta, sck_sync, sck_last;
    logic cs_meta, cs_sync;
    logic mosi_meta, mosi_sync;
    mbc_phase_type phase;
    logic [2:0] bit_cnt;
    logic [7:0] sh_in;
    logic [7:0] sh_out;
    logic miso, miso_oe, wr_mode, load_pend;
    logic [6:0] addr;
    logic [7:0] ptr, tx_base, rx_base, rx_cnt, tx_len, last_start;
    logic [7:0] mask, flags;
    logic long_range;
    logic [2:0] mode;
    logic [23:0] frf;
    logic clr_active;
    logic [7:0] clr_addr, rx_wr_ptr, tx_rd_ptr, tx_byte;
    logic irq, osc, pll_tx, pll_rx, rf_tx, rf_rx;
  } mbc_core_type;

  localparam mbc_core_type CORE_RST = '{
    cs_meta: 1'b1, cs_sync: 1'b1, phase: PH_ADDR,
    tx_base: RST_TX_BASE, rx_base: RST_RX_BASE, // R4
    mask: RST_IRQ_MASK, tx_len: RST_TX_LEN, // R15
    mode: MODE_STDBY, frf: RST_FRF, osc: 1'b1,
    default: '0
  };

  mbc_core_type st_reg;
  mbc_core_type st_next;
  logic [7:0] buf_mem [2**BUF_AW];
  logic ram_we;
  logic [7:0] ram_wa;
  logic [7:0] ram_wd;
  logic buf_open;
  logic byte_done;
  logic host_buf_we;
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_ready;
  logic rx_fire;
  logic [7:0] new_byte;
  logic [7:0] rd_val;
  logic [7:0] w1c;

  function automatic logic is_rx(input logic [2:0] m);
    return (m == MODE_RXCONT) || (m == MODE_RXONCE);
  endfunction

  // Stall source: RAM port busy or not receiving, so bytes wait here
  mbc_stream_fifo #(
    .WIDTH(RX_FIFO_WIDTH),
    .DEPTH(RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .in_data_i(RX_BYTE_I),
    .in_valid_i(RX_VALID_I),
    .in_ready_o(RX_READY_O),
    .out_data_o(rx_data),
    .out_valid_o(rx_valid),
    .out_ready_i(rx_ready)
  );

  always_comb begin
    st_next = st_reg;
    ram_we = 1'b0;
    ram_wa = st_reg.ptr;
    ram_wd = 8'h00;
    host_buf_we = 1'b0;
    w1c = 8'h00;
    rd_val = 8'h00;
    byte_done = 1'b0;
    new_byte = {st_reg.sh_in[6:0], st_reg.mosi_sync};
    buf_open = st_reg.long_range && (st_reg.mode != MODE_SLEEP) &&
               !st_reg.clr_active; // R2 R6 R18
    // Pin synchronisers
    st_next.sck_meta = SPI_SCK_I;
    st_next.sck_sync = st_reg.sck_meta;
    st_next.sck_last = st_reg.sck_sync;
    st_next.cs_meta = SPI_CS_N_I;
    st_next.cs_sync = st_reg.cs_meta;
    st_next.mosi_meta = SPI_MOSI_I;
    st_next.mosi_sync = st_reg.mosi_meta;

    // Register read mux, every mode including sleep
    if (st_reg.addr == ADDR_DATA_PORT) begin
      rd_val = buf_open ? buf_mem[st_reg.ptr] : 8'h00; // R3 R18
    end else if (st_reg.addr == ADDR_OPMODE) begin
      rd_val = {st_reg.long_range, 4'h0, st_reg.mode}; // R1
    end else if (st_reg.addr == ADDR_FRF_MSB) begin
      rd_val = st_reg.frf[23:16];
    end else if (st_reg.addr == ADDR_FRF_MID) begin
      rd_val = st_reg.frf[15:8];
    end else if (st_reg.addr == ADDR_FRF_LSB) begin
      rd_val = st_reg.frf[7:0];
    end else if (st_reg.addr == ADDR_PTR) begin
      rd_val = st_reg.ptr;
    end else if (st_reg.addr == ADDR_TX_BASE) begin
      rd_val = st_reg.tx_base;
    end else if (st_reg.addr == ADDR_RX_BASE) begin
      rd_val = st_reg.rx_base;
    end else if (st_reg.addr == ADDR_LAST_START) begin
      rd_val = st_reg.last_start;
    end else if (st_reg.addr == ADDR_IRQ_MASK) begin
      rd_val = st_reg.mask;
    end else if (st_reg.addr == ADDR_IRQ_FLAGS) begin
      rd_val = st_reg.flags;
    end else if (st_reg.addr == ADDR_RX_COUNT) begin
      rd_val = st_reg.rx_cnt;
    end else if (st_reg.addr == ADDR_TX_LEN) begin
      rd_val = st_reg.tx_len;
    end else begin
      rd_val = 8'h00;
    end

    // Modem driven returns to standby, overridden by a host write below
    if (st_reg.mode == MODE_TX && TX_DONE_I) begin
      st_next.mode = MODE_STDBY; // R20
    end
    if (st_reg.mode == MODE_RXONCE && RX_EVT_I.done) begin
      st_next.mode = MODE_STDBY; // R21
    end
    if (RX_EVT_I.start) begin
      st_next.last_start = st_reg.rx_wr_ptr; // R11
    end
    if (RX_EVT_I.hdr_valid && !IMPLICIT_HDR_I) begin
      st_next.rx_cnt = RX_EVT_I.hdr_len; // R10
    end

    // SPI slave, mode 0, MSB first
    if (st_reg.cs_sync) begin
      st_next.miso_oe = 1'b0;
      st_next.phase = PH_ADDR;
      st_next.bit_cnt = 3'h0;
      st_next.load_pend = 1'b0;
    end else begin
      st_next.miso_oe = 1'b1;
      if (st_reg.sck_sync && !st_reg.sck_last) begin
        st_next.sh_in = new_byte;
        st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
        byte_done = (st_reg.bit_cnt == 3'h7);
      end
      if (!st_reg.sck_sync && st_reg.sck_last && st_reg.bit_cnt != 3'h0) begin
        st_next.miso = st_reg.sh_out[7];
        st_next.sh_out = {st_reg.sh_out[6:0], 1'b0};
      end
      // Prefetch one cycle after the byte so the read sees updated state
      if (st_reg.load_pend) begin
        st_next.miso = rd_val[7];
        st_next.sh_out = {rd_val[6:0], 1'b0};
        st_next.load_pend = 1'b0;
      end
    end

    if (byte_done && st_reg.phase == PH_ADDR) begin
      st_next.phase = PH_DATA;
      st_next.wr_mode = new_byte[SPI_WRITE_BIT];
      st_next.addr = new_byte[6:0];
      st_next.load_pend = !new_byte[SPI_WRITE_BIT];
    end else if (byte_done) begin
      st_next.load_pend = !st_reg.wr_mode;
      if (st_reg.wr_mode) begin
        if (st_reg.addr == ADDR_DATA_PORT) begin
          host_buf_we = buf_open; // R6 R8
        end else if (st_reg.addr == ADDR_OPMODE) begin
          st_next.mode = new_byte[OPM_MODE_LSB +: 3]; // R22
          if (st_reg.mode == MODE_SLEEP) begin
            st_next.long_range = new_byte[OPM_LR_BIT]; // R17
          end
        end else if (st_reg.addr == ADDR_FRF_MSB) begin
          st_next.frf[23:16] = new_byte; // R23
        end else if (st_reg.addr == ADDR_FRF_MID) begin
          st_next.frf[15:8] = new_byte; // R23
        end else if (st_reg.addr == ADDR_FRF_LSB) begin
          st_next.frf[7:0] = new_byte; // R23
        end else if (st_reg.addr == ADDR_PTR) begin
          st_next.ptr = new_byte; // R9
        end else if (st_reg.addr == ADDR_TX_BASE) begin
          st_next.tx_base = new_byte; // R5
        end else if (st_reg.addr == ADDR_RX_BASE) begin
          st_next.rx_base = new_byte; // R5
        end else if (st_reg.addr == ADDR_IRQ_MASK) begin
          st_next.mask = new_byte; // R15
        end else if (st_reg.addr == ADDR_IRQ_FLAGS) begin
          w1c = new_byte; // R16
        end else if (st_reg.addr == ADDR_TX_LEN) begin
          st_next.tx_len = new_byte; // R10
        end
      end
      // Burst: data port holds its address, others step on
      if (st_reg.addr == ADDR_DATA_PORT) begin
        if (buf_open) begin
          st_next.ptr = st_reg.ptr + 8'h01; // R8 R14
        end
      end else begin
        st_next.addr = st_reg.addr + 7'h01;
      end
    end

    // Event wins over a same-cycle clear
    st_next.flags = (st_reg.flags & ~w1c) | IRQ_EVENT_I; // R16

    // Single write port: clear, then host, then receive stream
    rx_ready = st_reg.long_range && is_rx(st_reg.mode) &&
               !st_reg.clr_active && !host_buf_we;
    rx_fire = rx_ready && rx_valid;
    if (st_reg.clr_active) begin
      ram_we = 1'b1;
      ram_wa = st_reg.clr_addr;
      if (st_reg.clr_addr == BUF_LAST) begin
        st_next.clr_active = 1'b0;
      end
      st_next.clr_addr = st_reg.clr_addr + 8'h01;
    end else if (host_buf_we) begin
      ram_we = 1'b1; // R7
      ram_wa = st_reg.ptr;
      ram_wd = new_byte;
    end else if (rx_fire) begin
      ram_we = 1'b1; // R12 R13
      ram_wa = st_reg.rx_wr_ptr;
      ram_wd = rx_data;
      st_next.rx_wr_ptr = st_reg.rx_wr_ptr + 8'h01; // R14
    end

    // Mode entry last, so a new entry restarts a clear already running
    if (st_next.mode == MODE_SLEEP && st_reg.mode != MODE_SLEEP) begin
      st_next.clr_active = 1'b1; // R6
      st_next.clr_addr = 8'h00;
    end
    if (is_rx(st_next.mode) && !is_rx(st_reg.mode)) begin
      st_next.clr_active = 1'b1; // R3
      st_next.clr_addr = 8'h00;
      st_next.rx_wr_ptr = st_next.rx_base;
    end
    if (st_next.mode == MODE_TX && st_reg.mode != MODE_TX) begin
      st_next.tx_rd_ptr = st_next.tx_base;
    end

    if (TX_BYTE_REQ_I && st_reg.mode == MODE_TX && buf_open) begin
      st_next.tx_byte = buf_mem[st_reg.tx_rd_ptr];
      st_next.tx_rd_ptr = st_reg.tx_rd_ptr + 8'h01; // R14
    end

    // PLL and RF power only while long range is on; oscillator follows mode alone
    st_next.irq = |(st_reg.flags & ~st_reg.mask); // R15
    st_next.osc = st_next.mode != MODE_SLEEP; // R19
    st_next.pll_tx = st_next.long_range &&
      (st_next.mode == MODE_TRANSMIT_SYNTH_MODE || st_next.mode == MODE_TX); // R19
    st_next.pll_rx = st_next.long_range && (st_next.mode == MODE_RECEIVE_SYNTH_MODE ||
      is_rx(st_next.mode) || st_next.mode == MODE_CAD); // R19
    st_next.rf_tx = st_next.long_range && st_next.mode == MODE_TX; // R20
    st_next.rf_rx = st_next.long_range &&
      (is_rx(st_next.mode) || st_next.mode == MODE_CAD); // R21
  end

  // Buffer array keeps no reset; sleep entry clears it instead
  always_ff @(posedge CORE_CLK_I) begin
    if (ram_we) begin
      buf_mem[ram_wa] <= ram_wd;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_reg <= CORE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign SPI_MISO_O = st_reg.miso;
  assign SPI_MISO_OE_O = st_reg.miso_oe;
  assign TX_BYTE_O = st_reg.tx_byte;
  assign TX_LEN_O = st_reg.tx_len;
  assign MODE_O = st_reg.mode;
  assign LONG_RANGE_O = st_reg.long_range;
  assign FRF_O = st_reg.frf;
  assign OSC_ON_O = st_reg.osc;
  assign PLL_TX_ON_O = st_reg.pll_tx;
  assign PLL_RX_ON_O = st_reg.pll_rx;
  assign RF_TX_ON_O = st_reg.rf_tx;
  assign RF_RX_ON_O = st_reg.rf_rx;
  assign IRQ_O = st_reg.irq;

  a_sleep_starts_clear: assert property (@(posedge CORE_CLK_I) // R6
    disable iff (RST_I)
    (st_reg.mode != MODE_SLEEP && st_next.mode == MODE_SLEEP)
      |=> st_reg.clr_active && st_reg.clr_addr == 8'h00)
    else $error("sleep entry did not start buffer clear");

  a_sleep_no_write: assert property (@(posedge CORE_CLK_I) // R18
    disable iff (RST_I)
    (st_reg.mode == MODE_SLEEP && !st_reg.clr_active) |-> !ram_we)
    else $error("buffer written during sleep");

  a_rx_entry_clear: assert property (@(posedge CORE_CLK_I) // R3
    disable iff (RST_I)
    (!is_rx(st_reg.mode) && is_rx(st_next.mode))
      |=> st_reg.clr_active ##0 st_reg.rx_wr_ptr == st_reg.rx_base)
    else $error("receive entry did not clear buffer");

  a_ptr_wraps: assert property (@(posedge CORE_CLK_I) // R14
    disable iff (RST_I)
    rx_fire |=> st_reg.rx_wr_ptr == $past(st_reg.rx_wr_ptr) + 8'h01)
    else $error("receive pointer did not wrap");

  a_flag_set_wins: assert property (@(posedge CORE_CLK_I) // R16
    disable iff (RST_I)
    IRQ_EVENT_I[0] |=> st_reg.flags[0])
    else $error("event flag lost");

  a_flag_w1c: assert property (@(posedge CORE_CLK_I) // R16
    disable iff (RST_I)
    (w1c[0] && !IRQ_EVENT_I[0]) |=> !st_reg.flags[0])
    else $error("flag not cleared by write of one");

  a_mask_gates_irq: assert property (@(posedge CORE_CLK_I) // R15
    disable iff (RST_I)
    (|(st_reg.flags & ~st_reg.mask)) |=> IRQ_O)
    else $error("unmasked flag did not raise interrupt");

  a_tx_returns: assert property (@(posedge CORE_CLK_I) // R20
    disable iff (RST_I)
    (st_reg.mode == MODE_TX && TX_DONE_I && !byte_done)
      |=> st_reg.mode == MODE_STDBY ##1 !RF_TX_ON_O)
    else $error("transmit did not return to standby");

  a_rx_once_returns: assert property (@(posedge CORE_CLK_I) // R21
    disable iff (RST_I)
    (st_reg.mode == MODE_RXONCE && RX_EVT_I.done && !byte_done)
      |=> st_reg.mode == MODE_STDBY)
    else $error("single receive did not return to standby");

  a_rx_cont_stays: assert property (@(posedge CORE_CLK_I) // R21
    disable iff (RST_I)
    (st_reg.mode == MODE_RXCONT && RX_EVT_I.done && !byte_done)
      |=> st_reg.mode == MODE_RXCONT)
    else $error("continuous receive left its mode");

  a_lr_only_sleep: assert property (@(posedge CORE_CLK_I) // R17
    disable iff (RST_I)
    (st_reg.mode != MODE_SLEEP) |=> $stable(st_reg.long_range))
    else $error("long range bit changed outside sleep");

endmodule

/* mbc_spi_host.sv */
// Host controller model for the SPI register port, mode 0
`timescale 1ns/100ps

module mbc_spi_host #(
  parameter int HALF = 8
) (
  input wire logic clk_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i,
  input wire logic miso_oe_i
);
  logic miso_last = 1'b0;
  logic miso_line;

  // Released line shows the inverse of its last level, not a stale copy
  assign miso_line = miso_oe_i ? miso_i : ~miso_last;

  always @(posedge clk_i) begin
    if (miso_oe_i) begin
      miso_last <= miso_i;
    end
  end

  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  task automatic open_frame();
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (HALF) @(posedge clk_i);
  endtask

  // Half period of 8 clk leaves slack over the input synchroniser
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk_i);
      mosi_o <= tx[i];
      repeat (HALF) @(posedge clk_i);
      sck_o <= 1'b1;
      rx[i] = miso_line;
      repeat (HALF) @(posedge clk_i);
      sck_o <= 1'b0;
    end
  endtask

  // Gap of 4 clk keeps chip select high past the 3 clk minimum
  task automatic close_frame();
    @(posedge clk_i);
    cs_n_o <= 1'b1;
    mosi_o <= ~mosi_o;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

/* testbench.sv */
// Self-checking bench for the modem buffer and mode controller
`timescale 1ns/100ps

module testbench
  import mbc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sck, cs_n, mosi, miso, miso_oe, rx_ready;
  logic [7:0] rx_byte = 8'h00;
  logic rx_valid = 1'b0;
  mbc_rx_evt_type rx_evt = '0;
  logic implicit_hdr = 1'b0;
  logic tx_req = 1'b0;
  logic tx_done = 1'b0;
  logic [7:0] irq_ev = 8'h00;
  logic [7:0] tx_byte, tx_len, pw;
  logic [7:0] pwr;
  logic [2:0] mode;
  logic long_range, osc_on, pll_tx, pll_rx, rf_tx, rf_rx, irq;
  logic [23:0] frf;
  int fail_count = 0;
  int n_tests = 0;

  assign pwr = {mode, osc_on, pll_tx, pll_rx, rf_tx, rf_rx};

  initial begin
    forever #10 clk = ~clk;
  end

  mbc_modem_buffer dut_u (
    .CORE_CLK_I(clk),
    .RST_I(rst),
    .SPI_SCK_I(sck),
    .SPI_CS_N_I(cs_n),
    .SPI_MOSI_I(mosi),
    .SPI_MISO_O(miso),
    .SPI_MISO_OE_O(miso_oe),
    .RX_BYTE_I(rx_byte),
    .RX_VALID_I(rx_valid),
    .RX_READY_O(rx_ready),
    .RX_EVT_I(rx_evt),
    .IMPLICIT_HDR_I(implicit_hdr),
    .TX_BYTE_REQ_I(tx_req),
    .TX_DONE_I(tx_done),
    .IRQ_EVENT_I(irq_ev),
    .TX_BYTE_O(tx_byte),
    .TX_LEN_O(tx_len),
    .MODE_O(mode),
    .LONG_RANGE_O(long_range),
    .FRF_O(frf),
    .OSC_ON_O(osc_on),
    .PLL_TX_ON_O(pll_tx),
    .PLL_RX_ON_O(pll_rx),
    .RF_TX_ON_O(rf_tx),
    .RF_RX_ON_O(rf_rx),
    .IRQ_O(irq)
  );

  mbc_spi_host host_u (
    .clk_i(clk),
    .sck_o(sck),
    .cs_n_o(cs_n),
    .mosi_o(mosi),
    .miso_i(miso),
    .miso_oe_i(miso_oe)
  );

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One frame from one start address; bytes follow an arithmetic pattern
  task automatic burst(input logic [7:0] cmd, input int n,
                       input logic [7:0] v0, input logic [7:0] step);
    logic [7:0] x;
    host_u.open_frame();
    host_u.xfer(cmd, x);
    for (int i = 0; i < n; i++) begin
      host_u.xfer(v0 + step * i[7:0], x);
      if (!cmd[7]) chk({16'h0, x}, {16'h0, v0 + step * i[7:0]});
    end
    host_u.close_frame();
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    burst({1'b1, a}, 1, d, 8'h00);
  endtask

  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    burst({1'b0, a}, 1, e, 8'h00);
  endtask

  // Valid stays up between bytes; the caller lowers it
  task automatic push(input logic [7:0] b);
    int k;
    k = 0;
    rx_byte <= b;
    rx_valid <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (rx_ready !== 1'b1 && k < 40);
    if (k >= 40) begin
      chk(24'h0, 24'h1);
      tally_and_finish();
    end
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rchk(ADDR_TX_BASE, 8'h80);
    rchk(ADDR_RX_BASE, 8'h00);
    rchk(ADDR_IRQ_MASK, 8'h00);
    chk({12'h0, tx_len, long_range, mode}, {12'h0, 8'h01, 1'b0, 3'h1});
    wr(ADDR_PTR, 8'h10);
    wr(ADDR_DATA_PORT, 8'h99);
    rchk(ADDR_PTR, 8'h10);
    $display("test reset done");
    wr(ADDR_OPMODE, 8'h00);
    wr(ADDR_OPMODE, 8'h80);
    chk({20'h0, long_range, mode}, {20'h0, 1'b1, 3'h0});
    rchk(ADDR_DATA_PORT, 8'h00);
    rchk(ADDR_PTR, 8'h10);
    rchk(ADDR_TX_BASE, 8'h80);
    repeat (300) @(posedge clk);
    wr(ADDR_OPMODE, 8'h81);
    $display("test sleep done");
    wr(ADDR_PTR, 8'hfe);
    burst({1'b1, ADDR_DATA_PORT}, 3, 8'h11, 8'h11);
    rchk(ADDR_PTR, 8'h01);
    wr(ADDR_OPMODE, 8'h82);
    wr(ADDR_OPMODE, 8'h81);
    wr(ADDR_PTR, 8'hfe);
    burst({1'b0, ADDR_DATA_PORT}, 3, 8'h11, 8'h11);
    $display("test pointer done");
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_OPMODE, {5'b10000, m[2:0]});
      pw = {m[2:0], m != 0, m == 2 || m == 3, m >= 4, m == 3, m >= 5};
      chk({16'h0, pwr}, {16'h0, pw});
    end
    wr(ADDR_OPMODE, 8'h81);
    repeat (300) @(posedge clk);
    wr(ADDR_PTR, 8'hfe);
    burst({1'b0, ADDR_DATA_PORT}, 3, 8'h00, 8'h00);
    $display("test modes done");
    wr(ADDR_PTR, 8'h80);
    burst({1'b1, ADDR_DATA_PORT}, 2, 8'ha5, 8'h11);
    wr(ADDR_TX_LEN, 8'h02);
    chk({16'h0, tx_len}, 24'h000002);
    wr(ADDR_OPMODE, 8'h83);
    @(posedge clk);
    tx_req <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk({16'h0, tx_byte}, 24'h0000a5);
    @(posedge clk);
    tx_req <= 1'b0;
    @(negedge clk);
    chk({16'h0, tx_byte}, 24'h0000b6);
    @(posedge clk);
    tx_done <= 1'b1;
    @(posedge clk);
    tx_done <= 1'b0;
    @(negedge clk);
    chk({21'h0, mode}, {21'h0, MODE_STDBY});
    $display("test transmit done");
    // Stream buffer fills while the receive clear still blocks the drain
    wr(ADDR_RX_BASE, 8'h7f);
    wr(ADDR_OPMODE, 8'h86);
    rx_evt <= {1'b1, 1'b1, 8'h20, 1'b0};
    @(posedge clk);
    rx_evt <= '0;
    for (int i = 0; i < 32; i++) begin
      push(8'h40 + i[7:0]);
    end
    rx_valid <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk({23'h0, rx_ready}, 24'h0);
    repeat (300) @(posedge clk);
    rx_evt <= {1'b0, 1'b0, 8'h00, 1'b1};
    @(posedge clk);
    rx_evt <= '0;
    @(negedge clk);
    chk({21'h0, mode}, {21'h0, MODE_STDBY});
    rchk(ADDR_LAST_START, 8'h7f);
    rchk(ADDR_RX_COUNT, 8'h20);
    wr(ADDR_PTR, 8'h7f);
    burst({1'b0, ADDR_DATA_PORT}, 32, 8'h40, 8'h01);
    implicit_hdr <= 1'b1;
    wr(ADDR_OPMODE, 8'h85);
    rx_evt <= {1'b0, 1'b1, 8'h09, 1'b1};
    @(posedge clk);
    rx_evt <= '0;
    wr(ADDR_RX_COUNT, 8'h55);
    rchk(ADDR_RX_COUNT, 8'h20);
    chk({21'h0, mode}, {21'h0, MODE_RXCONT});
    wr(ADDR_OPMODE, 8'h81);
    wr(ADDR_OPMODE, 8'h01);
    chk({20'h0, long_range, mode}, {20'h0, 1'b1, 3'h1});
    $display("test receive done");
    irq_ev <= 8'h05;
    @(posedge clk);
    irq_ev <= 8'h00;
    repeat (3) @(posedge clk);
    chk({23'h0, irq}, 24'h1);
    rchk(ADDR_IRQ_FLAGS, 8'h05);
    wr(ADDR_IRQ_MASK, 8'h05);
    chk({23'h0, irq}, 24'h0);
    wr(ADDR_IRQ_FLAGS, 8'h01);
    rchk(ADDR_IRQ_FLAGS, 8'h04);
    wr(ADDR_IRQ_MASK, 8'h00);
    chk({23'h0, irq}, 24'h1);
    wr(ADDR_IRQ_FLAGS, 8'h04);
    chk({23'h0, irq}, 24'h0);
    $display("test interrupt done");
    burst({1'b1, ADDR_FRF_MSB}, 3, 8'h6c, 8'h14);
    chk(frf, 24'h6c8094);
    burst({1'b0, ADDR_FRF_MSB}, 3, 8'h6c, 8'h14);
    rchk(7'h30, 8'h00);
    $display("test carrier done");
    tally_and_finish();
  end
endmodule
